// ===== shared/iscl_pkg.sv
// Shared constants and types for the instruction state count logic
package iscl_pkg;

  // Width of a states-per-cycle figure and of a computed total
  localparam int unsigned ISCL_RATE_W = 8;
  localparam int unsigned ISCL_TOTAL_W = 10;

  // States per cycle, on-chip memory and internal operation
  localparam logic [7:0] ISCL_RATE_ONCHIP = 8'h02;
  localparam logic [7:0] ISCL_RATE_INTERNAL = 8'h01;
  // States per cycle, on-chip supporting module
  localparam logic [7:0] ISCL_RATE_SUP8_WORD = 8'h06;
  localparam logic [7:0] ISCL_RATE_SUP8_BYTE = 8'h03;
  localparam logic [7:0] ISCL_RATE_SUP16 = 8'h03;
  // States per cycle, external device on an 8-bit bus
  localparam logic [7:0] ISCL_RATE_EXT8_2S_WORD = 8'h04;
  localparam logic [7:0] ISCL_RATE_EXT8_2S_BYTE = 8'h02;
  localparam logic [7:0] ISCL_RATE_EXT8_3S_WORD = 8'h06;
  localparam logic [7:0] ISCL_RATE_EXT8_3S_BYTE = 8'h03;
  // States per cycle, external device on a 16-bit bus
  localparam logic [7:0] ISCL_RATE_EXT16_2S = 8'h02;
  localparam logic [7:0] ISCL_RATE_EXT16_3S = 8'h03;

  // Cycle counts used by the decoder
  localparam logic [1:0] ISCL_CYC_NONE = 2'h0;
  localparam logic [1:0] ISCL_CYC_ONE = 2'h1;
  localparam logic [1:0] ISCL_CYC_TWO = 2'h2;
  localparam logic [1:0] ISCL_CYC_THREE = 2'h3;

  // Latency from request to answer, in clock cycles
  localparam int unsigned ISCL_LATENCY = 1;

  // Access target of a cycle
  typedef enum logic [1:0] {
    ISCL_TGT_MEM = 2'h0, // On-chip memory
    ISCL_TGT_SUP = 2'h1, // On-chip supporting module
    ISCL_TGT_EXT = 2'h2  // External device
  } iscl_tgt_t;

  // Instruction forms handled by the decoder
  typedef enum logic [4:0] {
    ISCL_OP_ADD_B_IMM = 5'h00,
    ISCL_OP_ADD_B_REG = 5'h01,
    ISCL_OP_ADD_W_IMM = 5'h02,
    ISCL_OP_ADD_W_REG = 5'h03,
    ISCL_OP_ADD_L_IMM = 5'h04,
    ISCL_OP_ADD_L_REG = 5'h05,
    ISCL_OP_ADD_SMALL_CONSTANT = 5'h06,
    ISCL_OP_ADD_WITH_EXTEND_IMM = 5'h07,
    ISCL_OP_ADD_WITH_EXTEND_REG = 5'h08,
    ISCL_OP_AND_B_IMM = 5'h09,
    ISCL_OP_AND_B_REG = 5'h0A,
    ISCL_OP_AND_W_IMM = 5'h0B,
    ISCL_OP_AND_W_REG = 5'h0C,
    ISCL_OP_AND_L_IMM = 5'h0D,
    ISCL_OP_AND_L_REG = 5'h0E,
    ISCL_OP_AND_CONDITION_CODE = 5'h0F,
    ISCL_OP_BIT_AND_REG = 5'h10,
    ISCL_OP_BIT_AND_IND = 5'h11,
    ISCL_OP_BIT_AND_ABS = 5'h12,
    ISCL_OP_BRANCH_D8 = 5'h13
  } iscl_op_t;

  // Highest legal instruction code
  localparam logic [4:0] ISCL_OP_LAST = 5'h13;

endpackage

// ===== design/iscl_cycle_rate.sv
// States-per-cycle selection for one kind of bus cycle
`timescale 1ns/10ps
module iscl_cycle_rate
  import iscl_pkg::*;
#(
  parameter int unsigned WAIT_W = 3
) (
  // Access conditions
  input wire logic [1:0] tgt_i,
  input wire logic byte_i,
  input wire logic sup_wide_i,
  input wire logic ext_wide_i,
  input wire logic ext_three_i,
  input wire logic [WAIT_W-1:0] wait_i,
  // Result
  output logic [7:0] rate_o
);

  // Wait count widened to the rate width
  wire logic [7:0] wait_w = 8'(wait_i);

  // Supporting module: 16-bit path is flat, 8-bit path splits byte and word
  wire logic [7:0] sup_rate = sup_wide_i ? ISCL_RATE_SUP16 :
    (byte_i ? ISCL_RATE_SUP8_BYTE : ISCL_RATE_SUP8_WORD);

  // External 8-bit bus, two-state access
  wire logic [7:0] ext8_2s = byte_i ? ISCL_RATE_EXT8_2S_BYTE : ISCL_RATE_EXT8_2S_WORD;

  // External 8-bit bus, three-state access: word pays the wait twice
  wire logic [7:0] ext8_3s = byte_i ? 8'(ISCL_RATE_EXT8_3S_BYTE + wait_w) :
    8'(ISCL_RATE_EXT8_3S_WORD + (wait_w << 1));

  // External 16-bit bus: same figure for every cycle kind
  wire logic [7:0] ext16 = ext_three_i ? 8'(ISCL_RATE_EXT16_3S + wait_w) : ISCL_RATE_EXT16_2S;

  // External selection by bus width and access type
  wire logic [7:0] ext_rate = ext_wide_i ? ext16 : (ext_three_i ? ext8_3s : ext8_2s);

  // Final selection by target; unused code treated as on-chip memory
  assign rate_o = (tgt_i == ISCL_TGT_SUP) ? sup_rate :
                  (tgt_i == ISCL_TGT_EXT) ? ext_rate : ISCL_RATE_ONCHIP;

endmodule

// ===== design/iscl_state_calc.sv
// Execution-state count calculator for a group of instruction forms
//
// Overview of operation
// - Total is sum of counts times rates
// - On-chip memory two states; internal one state
// - Supporting module: 8-bit 6/3, 16-bit 3
// - External bus: 4/2, 6+2m/3+m, 2 or 3+m
// - Add and logical AND fetch counts by size
// - Bit AND, branches, extend, condition code counts
`timescale 1ns/10ps
module iscl_state_calc
  import iscl_pkg::*;
#(
  parameter int unsigned WAIT_W = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Request
  input wire logic start_i,
  input wire logic [4:0] instr_i,
  // Access targets per cycle group
  input wire logic [1:0] prog_tgt_i,
  input wire logic [1:0] stack_tgt_i,
  input wire logic [1:0] data_tgt_i,
  // Bus conditions
  input wire logic sup_wide_i,
  input wire logic ext_wide_i,
  input wire logic ext_three_i,
  input wire logic [WAIT_W-1:0] ext_wait_i,
  // Answer
  output logic done_o,
  output logic illegal_o,
  output logic [ISCL_TOTAL_W-1:0] total_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Per-cycle-kind rates

  // Kind 0 fetch and branch read, 1 stack, 2 byte data, 3 word data
  logic [1:0] kind_tgt [4];
  logic [7:0] kind_rate [4];

  // One rate selector per cycle kind
  for (genvar k = 0; k < 4; k++) begin : g_rate
    // Fetch side follows program target, stack its own, data the rest
    assign kind_tgt[k] = (k == 0) ? prog_tgt_i : ((k == 1) ? stack_tgt_i : data_tgt_i);

    iscl_cycle_rate #(
      .WAIT_W(WAIT_W)
    ) u_rate (
      .tgt_i(kind_tgt[k]),
      .byte_i(k == 2),
      .sup_wide_i(sup_wide_i),
      .ext_wide_i(ext_wide_i),
      .ext_three_i(ext_three_i),
      .wait_i(ext_wait_i),
      .rate_o(kind_rate[k])
    );
  end

  // Named rates for readability
  wire logic [7:0] rate_i = kind_rate[0];
  wire logic [7:0] rate_j = kind_rate[0];
  wire logic [7:0] rate_k = kind_rate[1];
  wire logic [7:0] rate_l = kind_rate[2];
  wire logic [7:0] rate_m = kind_rate[3];
  // Internal operation is always one state
  wire logic [7:0] rate_n = ISCL_RATE_INTERNAL;

  //////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  // Code within the handled range
  wire logic op_known = (instr_i <= ISCL_OP_LAST);

  // Forms that take three fetch cycles: longword immediates
  wire logic fetch3 = (instr_i == ISCL_OP_ADD_L_IMM) ||
                      (instr_i == ISCL_OP_AND_L_IMM);

  // Forms that take two fetch cycles
  wire logic fetch2 = (instr_i == ISCL_OP_ADD_W_IMM) ||
                      (instr_i == ISCL_OP_AND_W_IMM) ||
                      (instr_i == ISCL_OP_AND_L_REG) ||
                      (instr_i == ISCL_OP_BIT_AND_IND) ||
                      (instr_i == ISCL_OP_BIT_AND_ABS) ||
                      (instr_i == ISCL_OP_BRANCH_D8);

  // Memory-operand bit AND reads one byte
  wire logic byte1 = (instr_i == ISCL_OP_BIT_AND_IND) ||
                     (instr_i == ISCL_OP_BIT_AND_ABS);

  // Fetch count; every other handled form takes one fetch
  wire logic [1:0] cnt_i = !op_known ? ISCL_CYC_NONE :
                           fetch3 ? ISCL_CYC_THREE :
                           fetch2 ? ISCL_CYC_TWO : ISCL_CYC_ONE;

  // Byte data count
  wire logic [1:0] cnt_l = (op_known && byte1) ? ISCL_CYC_ONE : ISCL_CYC_NONE;

  // No handled form reads a branch address, touches the stack,
  // moves a word of data or spends an internal cycle
  wire logic [1:0] cnt_j = ISCL_CYC_NONE;
  wire logic [1:0] cnt_k = ISCL_CYC_NONE;
  wire logic [1:0] cnt_m = ISCL_CYC_NONE;
  wire logic [1:0] cnt_n = ISCL_CYC_NONE;

  //////////////////////////////////////////////////////////////////////////////
  // Weighted sum

  // Each term widened before the product so nothing is lost
  wire logic [ISCL_TOTAL_W-1:0] term_i = 10'(cnt_i) * 10'(rate_i);
  wire logic [ISCL_TOTAL_W-1:0] term_j = 10'(cnt_j) * 10'(rate_j);
  wire logic [ISCL_TOTAL_W-1:0] term_k = 10'(cnt_k) * 10'(rate_k);
  wire logic [ISCL_TOTAL_W-1:0] term_l = 10'(cnt_l) * 10'(rate_l);
  wire logic [ISCL_TOTAL_W-1:0] term_m = 10'(cnt_m) * 10'(rate_m);
  wire logic [ISCL_TOTAL_W-1:0] term_n = 10'(cnt_n) * 10'(rate_n);

  // Total states for the requested form
  wire logic [ISCL_TOTAL_W-1:0] total_d =
    term_i + term_j + term_k + term_l + term_m + term_n;

  //////////////////////////////////////////////////////////////////////////////
  // Answer registers

  logic done_q; // One-cycle answer strobe
  logic illegal_q; // Code outside the handled group
  logic [ISCL_TOTAL_W-1:0] total_q; // Held result

  // Strobe follows every request by one cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= start_i;
    end
  end

  // Result captured on a request, held otherwise
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      total_q <= '0;
      illegal_q <= 1'b0;
    end else if (start_i) begin
      total_q <= total_d;
      illegal_q <= !op_known;
    end
  end

  // Outputs straight from the registers
  assign done_o = done_q;
  assign illegal_o = illegal_q;
  assign total_o = total_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  // Answer arrives one cycle after request and holds the sum
  answer_timing_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    start_i |=> (done_o && total_o == $past(total_d))
  ) else $error("answer missing or wrong one cycle after request");

  // On-chip memory fetch and data cycles cost two states
  onchip_rate_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (prog_tgt_i == ISCL_TGT_MEM && data_tgt_i == ISCL_TGT_MEM)
      |-> (rate_i == 8'h02 && rate_l == 8'h02 && rate_m == 8'h02)
  ) else $error("on-chip memory rate is not two states");

  // Supporting module rates by path width
  support_rate_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (data_tgt_i == ISCL_TGT_SUP)
      |-> (sup_wide_i ? (rate_l == 8'h03 && rate_m == 8'h03)
                      : (rate_l == 8'h03 && rate_m == 8'h06))
  ) else $error("supporting module rate mismatch");

  // External 8-bit three-state rates grow with the wait count
  ext_narrow_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (data_tgt_i == ISCL_TGT_EXT && !ext_wide_i && ext_three_i)
      |-> (rate_m == 8'(8'h06 + 2 * ext_wait_i) && rate_l == 8'(8'h03 + ext_wait_i))
  ) else $error("external 8-bit three-state rate mismatch");

  // External bus two-state fetch rates, narrow and wide
  ext_other_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (prog_tgt_i == ISCL_TGT_EXT && !ext_three_i)
      |-> (rate_i == (ext_wide_i ? 8'h02 : 8'h04))
  ) else $error("external two-state fetch rate mismatch");

  // Longword immediate add from on-chip memory totals six states
  long_add_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (start_i && instr_i == ISCL_OP_ADD_L_IMM && prog_tgt_i == ISCL_TGT_MEM)
      |=> (total_o == 10'h006)
  ) else $error("longword immediate add total is not six");

  // Register logical AND of longwords needs two fetches
  long_and_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (start_i && instr_i == ISCL_OP_AND_L_REG) |=> (total_o == 10'(2 * $past(rate_i)))
  ) else $error("longword register AND total mismatch");

  // Memory-operand bit AND costs two fetches and one byte read
  bit_and_mem_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (start_i && (instr_i == ISCL_OP_BIT_AND_IND || instr_i == ISCL_OP_BIT_AND_ABS))
      |=> (total_o == 10'(2 * $past(rate_i) + $past(rate_l)) && !illegal_o)
  ) else $error("memory bit AND total mismatch");

  // Short branch costs exactly two fetches
  branch_short_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (start_i && instr_i == ISCL_OP_BRANCH_D8) |=> (total_o == 10'(2 * $past(rate_i)))
  ) else $error("short branch total mismatch");

  // Single-fetch forms cost one fetch
  single_fetch_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (start_i && (instr_i == ISCL_OP_ADD_SMALL_CONSTANT ||
                 instr_i == ISCL_OP_ADD_WITH_EXTEND_IMM ||
                 instr_i == ISCL_OP_AND_CONDITION_CODE ||
                 instr_i == ISCL_OP_BIT_AND_REG))
      |=> (total_o == 10'($past(rate_i)))
  ) else $error("single-fetch form total mismatch");

  // Unknown codes give zero and raise the flag
  unknown_code_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (start_i && instr_i > ISCL_OP_LAST) |=> (illegal_o && total_o == 10'h000)
  ) else $error("unknown code not flagged");

endmodule

// ===== dv/iscl_bus_env.sv
// Model of the bus environment that sets the access conditions
`timescale 1ns/10ps
module iscl_bus_env
  import iscl_pkg::*;
(
  // Selected bus setup
  input wire logic [2:0] sel_i,
  // Access conditions seen by the calculator
  output logic [1:0] prog_tgt_o,
  output logic [1:0] stack_tgt_o,
  output logic [1:0] data_tgt_o,
  output logic sup_wide_o,
  output logic ext_wide_o,
  output logic ext_three_o,
  output logic [2:0] ext_wait_o
);
  // Packed setup: prog, stack, data targets, sup wide, ext wide, three, waits
  logic [11:0] setup_w;

  ////////////////////////////////////////////////////////////////////////////
  // Table of bus setups
  always_comb begin
    case (sel_i)
      3'h1: setup_w = {2'h1, 2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 3'h0}; // Module, 8-bit
      3'h2: setup_w = {2'h1, 2'h1, 2'h1, 1'b1, 1'b0, 1'b0, 3'h0}; // Module, 16-bit
      3'h3: setup_w = {2'h2, 2'h2, 2'h2, 1'b0, 1'b0, 1'b0, 3'h0}; // Ext 8-bit 2-state
      3'h4: setup_w = {2'h2, 2'h2, 2'h2, 1'b0, 1'b0, 1'b1, 3'h5}; // Ext 8-bit, 5 waits
      3'h5: setup_w = {2'h2, 2'h2, 2'h2, 1'b0, 1'b1, 1'b0, 3'h6}; // Waits unused
      3'h6: setup_w = {2'h2, 2'h2, 2'h2, 1'b0, 1'b1, 1'b1, 3'h7}; // Ext 16-bit, 7 waits
      3'h7: setup_w = {2'h3, 2'h0, 2'h2, 1'b0, 1'b0, 1'b1, 3'h0}; // Mixed, no waits
      default: setup_w = 12'h000; // All on-chip memory
    endcase
  end

  // Unpack onto the condition lines
  assign {prog_tgt_o, stack_tgt_o, data_tgt_o, sup_wide_o, ext_wide_o, ext_three_o,
          ext_wait_o} = setup_w;
endmodule

// ===== dv/testbench.sv
// Self-checking testbench for the instruction state count logic
`timescale 1ns/10ps
module testbench
  import iscl_pkg::*;
;
  // Clock, reset and request
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic start_i = 1'b0;
  logic [4:0] instr_i = 5'h00;
  logic [2:0] sel = 3'h0;
  // Conditions from the environment model
  logic [1:0] prog_tgt, stack_tgt, data_tgt;
  logic sup_wide, ext_wide, ext_three;
  logic [2:0] ext_wait;
  // Answer
  logic done_o, illegal_o;
  logic [ISCL_TOTAL_W-1:0] total_o;
  // Bookkeeping
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Instances
  iscl_bus_env i_iscl_bus_env (.sel_i(sel), .prog_tgt_o(prog_tgt), .stack_tgt_o(stack_tgt),
    .data_tgt_o(data_tgt), .sup_wide_o(sup_wide), .ext_wide_o(ext_wide),
    .ext_three_o(ext_three), .ext_wait_o(ext_wait));
  iscl_state_calc #(.WAIT_W(3)) i_iscl_state_calc (.clk_i(clk_i), .rstn_i(rstn_i),
    .start_i(start_i), .instr_i(instr_i), .prog_tgt_i(prog_tgt), .stack_tgt_i(stack_tgt),
    .data_tgt_i(data_tgt), .sup_wide_i(sup_wide), .ext_wide_i(ext_wide),
    .ext_three_i(ext_three), .ext_wait_i(ext_wait), .done_o(done_o),
    .illegal_o(illegal_o), .total_o(total_o));

  // Free-running 25 MHz clock
  always #20 clk_i = ~clk_i;

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparisons and verdict
  task automatic check_flag(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_total(input string name, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Expected figures
  // States for one cycle at a target
  function automatic int rate_of(input logic [1:0] tgt, input logic is_byte);
    int m;
    m = ext_wait;
    if (tgt == 2'h1) return sup_wide ? 3 : (is_byte ? 3 : 6);
    if (tgt == 2'h2) begin
      if (ext_wide) return ext_three ? 3 + m : 2;
      if (ext_three) return is_byte ? 3 + m : 6 + 2 * m;
      return is_byte ? 2 : 4;
    end
    return 2;
  endfunction

  // Fetches plus one byte access for memory bit operands
  function automatic logic [9:0] expect_of(input logic [4:0] c);
    int i;
    int l;
    if (c > 5'h13) return 10'h000;
    i = 1;
    l = (c == 5'h11 || c == 5'h12) ? 1 : 0;
    if (c inside {5'h02, 5'h0B, 5'h0E, 5'h11, 5'h12, 5'h13}) i = 2;
    if (c == 5'h04 || c == 5'h0D) i = 3;
    return 10'(i * rate_of(prog_tgt, 1'b0) + l * rate_of(data_tgt, 1'b1));
  endfunction

  // Answer of the request taken one edge ago
  task automatic see(input logic [4:0] c);
    check_flag("done", 1'b1, done_o);
    check_flag("illegal", c > 5'h13, illegal_o);
    check_total("total", expect_of(c), total_o);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Single request, then the pulse ends and the total holds
  task automatic ask(input logic [4:0] c);
    @(posedge clk_i);
    start_i <= 1'b1;
    instr_i <= c;
    @(posedge clk_i);
    start_i <= 1'b0;
    #1;
    see(c);
    @(posedge clk_i);
    #1;
    check_flag("done low", 1'b0, done_o);
    check_total("held", expect_of(c), total_o);
  endtask

  // Two requests on adjacent edges
  task automatic pair(input logic [4:0] a, input logic [4:0] b);
    @(posedge clk_i);
    start_i <= 1'b1;
    instr_i <= a;
    @(posedge clk_i);
    instr_i <= b;
    #1;
    see(a);
    @(posedge clk_i);
    start_i <= 1'b0;
    #1;
    see(b);
  endtask

  // Every handled code, 0 to 19, with all accesses on chip
  task automatic t_codes_onchip();
    @(posedge clk_i);
    sel <= 3'h0;
    for (int c = 0; c <= 19; c++) ask(5'(c));
  endtask

  // Bus setups with a fetch-only and a byte-access instruction
  task automatic t_bus_setups();
    for (int s = 1; s < 8; s++) begin
      @(posedge clk_i);
      sel <= 3'(s);
      ask(5'h11);
      ask(5'h04);
    end
  endtask

  // Back to back, illegal codes among them
  task automatic t_back_to_back();
    @(posedge clk_i);
    sel <= 3'h6;
    pair(5'h12, 5'h13);
    pair(5'h14, 5'h0E);
    pair(5'h1F, 5'h0D);
  endtask

  // Reset in mid-run clears the answer
  task automatic t_mid_reset();
    ask(5'h0D);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    #1;
    check_flag("done reset", 1'b0, done_o);
    check_flag("illegal reset", 1'b0, illegal_o);
    check_total("total reset", 10'h000, total_o);
    @(posedge clk_i);
    rstn_i <= 1'b1;
    ask(5'h10);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1;
    check_total("total after reset", 10'h000, total_o);
    t_codes_onchip();
    t_bus_setups();
    t_back_to_back();
    t_mid_reset();
    wrap_up();
  end
endmodule
